// ---- dmr_top.sv ----
// dmr_top: mode register one and two capture, decode and core configuration
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module dmr_top
    import dmr_pkg::*;
#(
    parameter int LOCK_CYCLES = DMR_LOCK_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // avalon-mm slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // dram command pins, asynchronous to i_clk
    input wire logic i_ck,
    input wire logic i_cke,
    input wire logic i_odt,
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic [2:0] i_ba,
    input wire logic [15:0] i_addr,
    // shared data mask / termination strobe pin pair
    input wire logic i_dm_termination_strobe,
    output logic o_dm_termination_strobe,
    output logic o_dm_termination_strobe_oe_n,
    output logic o_termination_strobe_c,
    output logic o_termination_strobe_c_oe_n,
    output logic o_data_mask,
    // core configuration
    output logic [1:0] o_drive_imp,
    output logic [DMR_LAT_W-1:0] o_additive_latency,
    output logic [DMR_LAT_W-1:0] o_read_latency,
    output logic [DMR_LAT_W-1:0] o_write_latency,
    output logic [DMR_LAT_W-1:0] o_cas_write_latency,
    output logic o_auto_self_refresh,
    output logic o_self_refresh_temp_range,
    output logic [2:0] o_partial_array_refresh,
    output logic o_write_leveling,
    output var dmr_term_t o_term,
    output logic o_dq_oe_n,
    // loop state and core timing
    output logic o_dll_on,
    output logic o_dll_locked,
    output logic o_self_refresh,
    output logic o_wr_term_ready,
    output logic o_int_read,
    output logic o_int_write,
    output logic o_rd_data_start,
    output logic o_wr_data_start
);
    dmr_pins_t pins_raw;
    dmr_pins_t pins;
    logic ck_prev_q;
    logic tick;

    // all pins share one synchroniser so they stay aligned to each other
    assign pins_raw = {i_ck, i_cke, i_odt, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_addr,
        i_dm_termination_strobe};

    dmr_sync #(.W($bits(dmr_pins_t))) u_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_async(pins_raw),
        .o_sync(pins)
    );

    // link rising edge; a 400 ns link period gives eight samples per cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) ck_prev_q <= 1'b0;
        else ck_prev_q <= pins.ck;
    end
    assign tick = pins.ck & ~ck_prev_q;

    // command decode at the link edge
    logic cmd_sel;
    logic cmd_mrs;
    logic cmd_ref;
    logic cmd_rd;
    logic cmd_wr;
    logic ld_mr1;
    logic ld_mr2;
    logic sr_enter;
    logic sr_exit;
    logic in_sr_q;
    assign cmd_sel = tick & ~pins.cs_n;
    assign cmd_mrs = cmd_sel & ~pins.ras_n & ~pins.cas_n & ~pins.we_n;
    assign cmd_ref = cmd_sel & ~pins.ras_n & ~pins.cas_n & pins.we_n;
    assign cmd_rd = cmd_sel & pins.ras_n & ~pins.cas_n & pins.we_n & ~in_sr_q;
    assign cmd_wr = cmd_sel & pins.ras_n & ~pins.cas_n & ~pins.we_n & ~in_sr_q;
    assign ld_mr1 = cmd_mrs & (pins.ba == DMR_BA_MR1);
    assign ld_mr2 = cmd_mrs & (pins.ba == DMR_BA_MR2);
    assign sr_enter = cmd_ref & ~pins.cke & ~in_sr_q;
    assign sr_exit = tick & pins.cke & in_sr_q;

    // mode registers keep their value until the next set to the same one
    logic [15:0] mr1_q;
    logic [15:0] mr2_q;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mr1_q <= DMR_MR_RST;
            mr2_q <= DMR_MR_RST;
        end else begin
            if (ld_mr1) mr1_q <= pins.addr;
            if (ld_mr2) mr2_q <= pins.addr;
        end
    end

    // field decode; reserved bits are stored but steer nothing
    logic dll_dis;
    logic [2:0] rtt_nom;
    logic [1:0] al_code;
    logic wlev;
    logic termination_strobe_en;
    logic qoff;
    logic [2:0] cwl_code;
    logic [1:0] rtt_wr;
    assign dll_dis = mr1_q[DMR_M1_DLL_DIS];
    assign o_drive_imp = {mr1_q[DMR_M1_ODI_HI], mr1_q[DMR_M1_ODI_LO]};
    assign rtt_nom = {mr1_q[DMR_M1_RTT_C], mr1_q[DMR_M1_RTT_B], mr1_q[DMR_M1_RTT_A]};
    assign al_code = mr1_q[DMR_M1_AL_LO +: 2];
    assign wlev = mr1_q[DMR_M1_WLEV];
    assign termination_strobe_en = mr1_q[DMR_M1_TERMINATION_STROBE];
    assign qoff = mr1_q[DMR_M1_QOFF];
    assign cwl_code = mr2_q[DMR_M2_CWL_LO +: 3];
    assign rtt_wr = mr2_q[DMR_M2_RTTWR_LO +: 2];
    assign o_partial_array_refresh = mr2_q[DMR_M2_PARTIAL_ARRAY_REFRESH_LO +: 3];
    assign o_auto_self_refresh = mr2_q[DMR_M2_ASR];
    assign o_self_refresh_temp_range = mr2_q[DMR_M2_SRT];
    assign o_write_leveling = wlev;

    // additive latency from its code and the cas latency
    function automatic logic [DMR_LAT_W-1:0] al_of(input logic [1:0] code,
        input logic [DMR_LAT_W-1:0] cl);
        unique case (code)
            2'b00: al_of = '0;
            2'b01: al_of = cl - DMR_LAT_W'(1);
            2'b10: al_of = cl - DMR_LAT_W'(2);
            default: al_of = '0; // reserved code: no added delay
        endcase
    endfunction : al_of

    // cas latency lives in mode register zero, outside this block, so software mirrors it
    logic [3:0] cl_q;
    logic [DMR_LAT_W-1:0] cl_w;
    logic [DMR_LAT_W-1:0] al;
    assign cl_w = {2'b00, cl_q};
    assign al = al_of(al_code, cl_w);
    assign o_additive_latency = al;
    assign o_cas_write_latency = DMR_CWL_BASE + {3'b000, cwl_code};
    assign o_read_latency = al + cl_w;
    assign o_write_latency = al + o_cas_write_latency;

    // self-refresh tracking; the loop follows it without a new mode set
    logic dll_on;
    logic dll_on_q;
    logic locked_q;
    logic lock_start;
    logic lock_done;
    always_ff @(posedge i_clk) begin
        if (i_reset) in_sr_q <= 1'b0;
        else if (sr_enter) in_sr_q <= 1'b1;
        else if (sr_exit) in_sr_q <= 1'b0;
    end
    assign dll_on = ~dll_dis & ~in_sr_q;
    assign lock_start = dll_on & ~dll_on_q;

    // lock wait restarts whenever the loop comes back on, including after reset
    dmr_timer #(.W(DMR_LOCK_W)) u_lock (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_tick(tick),
        .i_start(lock_start),
        .i_count(DMR_LOCK_W'(LOCK_CYCLES)),
        .o_busy(),
        .o_done(lock_done)
    );

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            dll_on_q <= 1'b0;
            locked_q <= 1'b0;
        end else begin
            dll_on_q <= dll_on;
            if (~dll_on | lock_start) locked_q <= 1'b0;
            else if (lock_done) locked_q <= 1'b1;
        end
    end
    assign o_dll_on = dll_on;
    assign o_dll_locked = locked_q;
    assign o_self_refresh = in_sr_q;
    // plain writes run without the loop; write termination needs it locked
    assign o_wr_term_ready = (rtt_wr == 2'b00) | locked_q;

    // commands are taken at once and held for the additive latency
    logic iss_rd_q;
    logic iss_done;
    logic issue_rd;
    logic issue_wr;
    logic al_zero;
    assign al_zero = (al == '0);
    dmr_timer #(.W(DMR_LAT_W)) u_issue (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_tick(tick),
        .i_start((cmd_rd | cmd_wr) & ~al_zero),
        .i_count(al),
        .o_busy(),
        .o_done(iss_done)
    );
    assign issue_rd = (cmd_rd & al_zero) | (iss_done & iss_rd_q);
    assign issue_wr = (cmd_wr & al_zero) | (iss_done & ~iss_rd_q);

    // only one command can wait out the additive latency at a time
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            iss_rd_q <= 1'b0;
            o_int_read <= 1'b0;
            o_int_write <= 1'b0;
        end else begin
            if (cmd_rd | cmd_wr) iss_rd_q <= cmd_rd;
            o_int_read <= issue_rd;
            o_int_write <= issue_wr;
        end
    end

    // internal command to first data: cas latency for reads, write cas for writes
    dmr_timer #(.W(DMR_LAT_W)) u_rd (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_tick(tick),
        .i_start(issue_rd),
        .i_count(cl_w),
        .o_busy(),
        .o_done(o_rd_data_start)
    );
    dmr_timer #(.W(DMR_LAT_W)) u_wr (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_tick(tick),
        .i_start(issue_wr),
        .i_count(o_cas_write_latency),
        .o_busy(),
        .o_done(o_wr_data_start)
    );

    // data phases of one eight-beat burst
    logic [2:0] rd_phase_q;
    logic [2:0] wr_phase_q;
    logic wr_active;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rd_phase_q <= 3'h0;
            wr_phase_q <= 3'h0;
        end else begin
            if (o_rd_data_start) rd_phase_q <= DMR_BURST_TICKS;
            else if (tick && rd_phase_q != 3'h0) rd_phase_q <= rd_phase_q - 3'h1;
            if (o_wr_data_start) wr_phase_q <= DMR_BURST_TICKS;
            else if (tick && wr_phase_q != 3'h0) wr_phase_q <= wr_phase_q - 3'h1;
        end
    end
    assign wr_active = (wr_phase_q != 3'h0);
    assign o_dq_oe_n = qoff | (rd_phase_q == 3'h0);

    // termination choice while odt is high: write value in writes outside leveling, nominal otherwise
    logic use_wr_term;
    dmr_term_t term_d;
    assign use_wr_term = pins.on_die_termination & wr_active & (rtt_wr != 2'b00) & ~wlev;
    assign term_d = use_wr_term ? dmr_term_t'{kind: DMR_TERM_WR, code: {1'b0, rtt_wr}} :
        (pins.on_die_termination && rtt_nom != 3'h0) ? dmr_term_t'{kind: DMR_TERM_NOM, code: rtt_nom} :
        dmr_term_t'{kind: DMR_TERM_OFF, code: 3'h0};

    // registered pad controls
    logic dm_q;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_term <= '{kind: DMR_TERM_OFF, code: 3'h0};
            dm_q <= 1'b0;
        end else begin
            o_term <= term_d;
            dm_q <= pins.dm & ~termination_strobe_en;
        end
    end
    assign o_data_mask = dm_q;

    // shared pins: termination only, no strobe, so drive fixed levels
    assign o_dm_termination_strobe = 1'b0;
    assign o_termination_strobe_c = 1'b1;
    assign o_dm_termination_strobe_oe_n = ~termination_strobe_en | qoff;
    assign o_termination_strobe_c_oe_n = ~termination_strobe_en | qoff;

    // avalon slave: one wait cycle, read data captured before the release
    logic ack_q;
    logic req;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    dmr_status_t status;
    assign req = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~ack_q;
    assign o_avs_readdata = rdata_q;
    assign status = '{wl: o_write_latency, rl: o_read_latency, wr_term_ready: o_wr_term_ready,
        outputs_off: qoff, self_refresh: in_sr_q, dll_locked: locked_q, dll_on: dll_on};
    assign rdata_d = (i_avs_address == DMR_OFS_MR1) ? {16'h0000, mr1_q} :
        (i_avs_address == DMR_OFS_MR2) ? {16'h0000, mr2_q} :
        (i_avs_address == DMR_OFS_STATUS) ? {15'h0000, status} :
        (i_avs_address == DMR_OFS_CTRL) ? {28'h0000000, cl_q} : 32'h00000000;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
            cl_q <= DMR_CL_RST;
        end else begin
            ack_q <= req & ~ack_q;
            if (i_avs_read & ~ack_q) rdata_q <= rdata_d;
            if (i_avs_write && ack_q && i_avs_address == DMR_OFS_CTRL && i_avs_byteenable[0])
                cl_q <= i_avs_writedata[3:0];
        end
    end

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    property p_mr1_load;
        ld_mr1 |=> mr1_q == $past(pins.addr);
    endproperty
    a_mr1_load: assert property (p_mr1_load) else $error("register one not loaded");

    property p_mr2_load;
        ld_mr2 |=> mr2_q == $past(pins.addr);
    endproperty
    a_mr2_load: assert property (p_mr2_load) else $error("register two not loaded");

    property p_hold;
        !ld_mr1 && !ld_mr2 |=> $stable(mr1_q) && $stable(mr2_q);
    endproperty
    a_hold: assert property (p_hold) else $error("mode register changed unasked");

    property p_qoff;
        qoff |-> o_dq_oe_n && o_dm_termination_strobe_oe_n && o_termination_strobe_c_oe_n;
    endproperty
    a_qoff: assert property (p_qoff) else $error("output driven while disabled");

    property p_sr_exit;
        sr_exit && !dll_dis && !ld_mr1 |=> o_dll_on && !o_dll_locked;
    endproperty
    a_sr_exit: assert property (p_sr_exit) else $error("loop not back after exit");

    property p_sr_off;
        o_self_refresh |-> !o_dll_on;
    endproperty
    a_sr_off: assert property (p_sr_off) else $error("loop on in self-refresh");

    property p_wr_term;
        rtt_wr != 2'b00 && !locked_q |-> !o_wr_term_ready;
    endproperty
    a_wr_term: assert property (p_wr_term) else $error("write termination unlocked");

    property p_odi;
        ld_mr1 |=> o_drive_imp == {$past(pins.addr[5]), $past(pins.addr[1])};
    endproperty
    a_odi: assert property (p_odi) else $error("driver impedance wrong");

    property p_al_code;
        al_code == 2'b10 |-> o_additive_latency == cl_w - 6'h02;
    endproperty
    a_al_code: assert property (p_al_code) else $error("additive latency wrong");

    property p_latency;
        o_write_latency - o_read_latency == o_cas_write_latency - cl_w;
    endproperty
    a_latency: assert property (p_latency) else $error("latency sum wrong");

    property p_issue;
        cmd_rd && al_zero |=> o_int_read;
    endproperty
    a_issue: assert property (p_issue) else $error("read not issued at once");

    property p_wlev;
        wlev |=> o_term.kind != DMR_TERM_WR;
    endproperty
    a_wlev: assert property (p_wlev) else $error("write termination in leveling");

    property p_rttwr;
        pins.on_die_termination && wr_active && rtt_wr != 2'b00 && !wlev && rtt_nom == 3'h0
            |=> o_term.kind == DMR_TERM_WR;
    endproperty
    a_rttwr: assert property (p_rttwr) else $error("write termination missing");

    property p_termination_strobe;
        !termination_strobe_en |-> o_dm_termination_strobe_oe_n && o_termination_strobe_c_oe_n;
    endproperty
    a_termination_strobe: assert property (p_termination_strobe) else $error("shared pin driven with mask");

    property p_cwl;
        ld_mr2 |=> o_cas_write_latency == DMR_CWL_BASE + {3'b000, $past(pins.addr[5:3])};
    endproperty
    a_cwl: assert property (p_cwl) else $error("write cas latency wrong");

    c_sr: cover property (sr_enter);
    c_rd_data: cover property (o_rd_data_start);
    c_wr_term: cover property (o_term.kind == DMR_TERM_WR);
endmodule : dmr_top
`default_nettype wire

// ---- dmr_pkg.sv ----
// dmr_pkg: constants, field positions and carrier types of the mode register block
//
// Overview of operation
// - mode set with bank 001 writes mode register one
// - output disable bit set: data, strobe and termination strobe drivers released
// - loop switches off at self-refresh entry and back on at exit
// - writes need the locked loop only when write termination is enabled
// - driver impedance comes from register one bits 5 and 1
// - write termination applies during writes even with nominal termination off
// - reads and writes accepted at once, issued internally after additive latency
// - read latency is additive plus cas; write latency additive plus write cas
// - additive latency code: 00 zero, 01 cl-1, 10 cl-2, 11 reserved
// - termination strobe enabled drives shared pins; disabled gives data mask
// - cas write latency comes from register two bits 5 to 3
// - write termination from register two bits 10:9, never during write leveling
// - mode set with bank 010 writes mode register two
package dmr_pkg;
    // avalon byte offsets
    localparam logic [3:0] DMR_OFS_MR1 = 4'h0;
    localparam logic [3:0] DMR_OFS_MR2 = 4'h4;
    localparam logic [3:0] DMR_OFS_STATUS = 4'h8;
    localparam logic [3:0] DMR_OFS_CTRL = 4'hc;
    // values after reset
    localparam logic [15:0] DMR_MR_RST = 16'h0000;
    localparam logic [3:0] DMR_CL_RST = 4'h5;
    // mode register one field positions
    localparam int DMR_M1_DLL_DIS = 0;
    localparam int DMR_M1_ODI_LO = 1;
    localparam int DMR_M1_RTT_A = 2;
    localparam int DMR_M1_AL_LO = 3;
    localparam int DMR_M1_ODI_HI = 5;
    localparam int DMR_M1_RTT_B = 6;
    localparam int DMR_M1_WLEV = 7;
    localparam int DMR_M1_RTT_C = 9;
    localparam int DMR_M1_TERMINATION_STROBE = 11;
    localparam int DMR_M1_QOFF = 12;
    // mode register two field positions
    localparam int DMR_M2_PARTIAL_ARRAY_REFRESH_LO = 0;
    localparam int DMR_M2_CWL_LO = 3;
    localparam int DMR_M2_ASR = 6;
    localparam int DMR_M2_SRT = 7;
    localparam int DMR_M2_RTTWR_LO = 9;
    // bank selects of the two registers
    localparam logic [2:0] DMR_BA_MR1 = 3'h1;
    localparam logic [2:0] DMR_BA_MR2 = 3'h2;
    // latency widths and counts, in link clock cycles
    localparam int DMR_LAT_W = 6;
    localparam logic [5:0] DMR_CWL_BASE = 6'h05;
    localparam logic [2:0] DMR_BURST_TICKS = 3'h4;
    localparam int DMR_LOCK_W = 12;
    localparam int DMR_LOCK_CYCLES = 512;

    // command pins in sampling order
    typedef struct packed {
        logic ck;
        logic cke;
        logic on_die_termination;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [15:0] addr;
        logic dm;
    } dmr_pins_t;

    typedef enum logic [1:0] {DMR_TERM_OFF, DMR_TERM_NOM, DMR_TERM_WR} dmr_term_kind_t;

    // active termination handed to the data pads
    typedef struct packed {
        dmr_term_kind_t kind;
        logic [2:0] code;
    } dmr_term_t;

    // status register layout, low bits first from the right
    typedef struct packed {
        logic [5:0] wl;
        logic [5:0] rl;
        logic wr_term_ready;
        logic outputs_off;
        logic self_refresh;
        logic dll_locked;
        logic dll_on;
    } dmr_status_t;
endpackage : dmr_pkg

// ---- dmr_sync.sv ----
// dmr_sync: two-stage synchroniser for a group of pins
`timescale 1ns/1ns
`default_nettype none
module dmr_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // pins and synchronised copy
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : dmr_sync
`default_nettype wire

// ---- dmr_timer.sv ----
// dmr_timer: counts link clock ticks after a start and pulses when done
`timescale 1ns/1ns
`default_nettype none
module dmr_timer #(
    parameter int W = 6
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // control
    input wire logic i_tick,
    input wire logic i_start,
    input wire logic [W-1:0] i_count,
    // status
    output logic o_busy,
    output logic o_done
);
    logic [W-1:0] cnt_q;
    logic busy_q;
    logic done_q;
    logic last;

    assign last = busy_q & i_tick & (cnt_q == W'(1));
    assign o_busy = busy_q;
    assign o_done = done_q;

    // a new start restarts the count; one job at a time
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (i_start) begin
            cnt_q <= i_count;
            busy_q <= (i_count != '0);
            done_q <= (i_count == '0);
        end else begin
            done_q <= last;
            if (busy_q & i_tick) cnt_q <= cnt_q - W'(1);
            if (last) busy_q <= 1'b0;
        end
    end
endmodule : dmr_timer
`default_nettype wire

// ---- dmr_ctrl_model.sv ----
// dmr_ctrl_model: memory controller driving the link command pins
`timescale 1ns/1ns
`default_nettype none
module dmr_ctrl_model
    import dmr_pkg::*;
(
    // core clock
    input wire logic i_clk,
    // link pins towards the device
    output var dmr_pins_t o_pins
);
    // idle: deselected, clock enable high, link clock standing low
    initial begin
        o_pins = {1'b0, 1'b1, 1'b0, 4'hf, 3'h7, 16'hffff, 1'b1};
    end
    // termination pin, changed right after a core clock edge and held across frames
    task automatic set_term(input logic on);
        o_pins.on_die_termination <= on;
    endtask : set_term
    // one 400 ns frame; setup 200 ns, hold 150 ns around the rise
    task automatic cmd(input logic cke, input logic [3:0] rcw, input logic [2:0] ba,
                       input logic [15:0] a);
        o_pins.cke <= cke;
        {o_pins.cs_n, o_pins.ras_n, o_pins.cas_n, o_pins.we_n} <= rcw;
        o_pins.ba <= ba;
        o_pins.addr <= a;
        repeat (4) @(posedge i_clk);
        o_pins.ck <= 1'b1;
        repeat (3) @(posedge i_clk);
        // released lines go to the inverse so stale values never pass
        {o_pins.cs_n, o_pins.ras_n, o_pins.cas_n, o_pins.we_n} <= {1'b1, ~rcw[2:0]};
        o_pins.ba <= ~ba;
        o_pins.addr <= ~a;
        @(posedge i_clk);
        o_pins.ck <= 1'b0;
    endtask : cmd
endmodule : dmr_ctrl_model
`default_nettype wire

// ---- dmr_top_tb_top.sv ----
// dmr_top_tb_top: self-checking bench of the mode register block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module dmr_top_tb_top;
    import dmr_pkg::*;
    logic i_clk, i_reset, avs_read, avs_write, wait_req;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, rdata, d;
    logic dm_o, dm_oe_n, tc_o, tc_oe_n, data_mask, automatic_self_refresh, self_refresh_temp_range, wlev, dq_oe_n;
    logic dll_on, locked, sref, wtr, irin, iwr, rds, wrs;
    logic [1:0] imp;
    logic [5:0] al, rl, wl, cas_write_latency;
    logic [2:0] partial_array_refresh;
    dmr_term_t term;
    dmr_pins_t pins;
    int mismatches, n_compared, cycles;
    logic [7:0] n_ir, n_iw, n_rs, n_ws, n_dq, n_wt;
    dmr_ctrl_model m (.i_clk(i_clk), .o_pins(pins));
    dmr_top #(.LOCK_CYCLES(4)) uut (.i_clk(i_clk), .i_reset(i_reset),
        .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
        .i_avs_writedata(avs_writedata), .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_req), .i_ck(pins.ck), .i_cke(pins.cke), .i_odt(pins.on_die_termination),
        .i_cs_n(pins.cs_n), .i_ras_n(pins.ras_n), .i_cas_n(pins.cas_n), .i_we_n(pins.we_n),
        .i_ba(pins.ba), .i_addr(pins.addr), .i_dm_termination_strobe(pins.dm), .o_dm_termination_strobe(dm_o),
        .o_dm_termination_strobe_oe_n(dm_oe_n), .o_termination_strobe_c(tc_o), .o_termination_strobe_c_oe_n(tc_oe_n),
        .o_data_mask(data_mask), .o_drive_imp(imp), .o_additive_latency(al),
        .o_read_latency(rl), .o_write_latency(wl), .o_cas_write_latency(cas_write_latency),
        .o_auto_self_refresh(automatic_self_refresh), .o_self_refresh_temp_range(self_refresh_temp_range),
        .o_partial_array_refresh(partial_array_refresh), .o_write_leveling(wlev), .o_term(term),
        .o_dq_oe_n(dq_oe_n), .o_dll_on(dll_on), .o_dll_locked(locked), .o_self_refresh(sref),
        .o_wr_term_ready(wtr), .o_int_read(irin), .o_int_write(iwr), .o_rd_data_start(rds),
        .o_wr_data_start(wrs));
    // 20 MHz core clock
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    task automatic results;
        if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            results;
        end
    end
    // event counters, read at the falling edge where pulses are settled
    always @(negedge i_clk) begin
        n_ir <= n_ir + {7'h0, irin};
        n_iw <= n_iw + {7'h0, iwr};
        n_rs <= n_rs + {7'h0, rds};
        n_ws <= n_ws + {7'h0, wrs};
        n_dq <= n_dq + {7'h0, ~dq_oe_n};
        n_wt <= n_wt + {7'h0, term.kind == DMR_TERM_WR};
    end
    // avalon access; request held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] w);
        @(posedge i_clk);
        avs_address <= a;
        avs_writedata <= w;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        do @(posedge i_clk); while (wait_req !== 1'b0);
        d = rdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : av
    // link frame, then let the synchroniser and decode settle
    task automatic link(input logic cke, input logic [3:0] rcw, input logic [2:0] ba,
                        input logic [15:0] a);
        m.cmd(cke, rcw, ba, a);
        repeat (4) @(posedge i_clk);
    endtask : link
    initial begin
        {i_reset, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 38'h0};
        {mismatches, n_compared, cycles} = {32'h0, 32'h0, 32'h0};
        {n_ir, n_iw, n_rs, n_ws, n_dq, n_wt} = 48'h0;
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (3) @(posedge i_clk);
        av(1'b0, DMR_OFS_STATUS, 32'h0);
        `CHK("status", {15'h0, 6'h05, 6'h05, 5'h11}, d)
        av(1'b0, 4'h2, 32'h0);
        `CHK("unmapped", 32'h0, d)
        repeat (5) link(1'b1, 4'hf, 3'h0, 16'h0);
        `CHK("locked", 1'b1, locked)
        av(1'b1, DMR_OFS_CTRL, 32'h6);
        for (int i = 0; i < 3; i++) begin
            link(1'b1, 4'h0, DMR_BA_MR1, 16'(i << 3));
            `CHK("al", 6'((6 - i) % 6), al)
            `CHK("rl", 6'((6 - i) % 6 + 6), rl)
        end
        // sixteen-bit part: termination strobe stays off
        link(1'b1, 4'h0, DMR_BA_MR1, 16'h0028);
        `CHK("imp", 2'b10, imp)
        `CHK("termination_strobe", 4'hd, {dm_oe_n, tc_oe_n, dm_o, tc_o})
        `CHK("dm on", 1'b1, data_mask)
        link(1'b1, 4'h0, DMR_BA_MR2, 16'h025a);
        `CHK("cwl", 6'h08, cas_write_latency)
        `CHK("wl", 6'h0d, wl)
        `CHK("asr", 1'b1, automatic_self_refresh)
        `CHK("refresh", 4'h2, {self_refresh_temp_range, partial_array_refresh})
        link(1'b1, 4'h0, 3'h3, 16'hffff);
        av(1'b0, DMR_OFS_MR1, 32'h0);
        `CHK("mr1 kept", 32'h0028, d)
        av(1'b0, DMR_OFS_MR2, 32'h0);
        `CHK("mr2 kept", 32'h025a, d)
        link(1'b1, 4'h0, DMR_BA_MR1, 16'h0000);
        `CHK("dm pin", 3'b111, {dm_oe_n, tc_oe_n, data_mask})
        // read then write at zero additive latency: cas 6, write cas 8 link cycles
        link(1'b1, 4'h5, 3'h0, 16'h0);
        m.set_term(1'b1);
        link(1'b1, 4'h4, 3'h0, 16'h0);
        repeat (4) link(1'b1, 4'hf, 3'h0, 16'h0);
        `CHK("rd early", 8'h00, n_rs)
        link(1'b1, 4'hf, 3'h0, 16'h0);
        `CHK("rd data", 16'h0100, {n_rs, n_ws})
        repeat (2) link(1'b1, 4'hf, 3'h0, 16'h0);
        `CHK("wr early", 8'h00, n_ws)
        link(1'b1, 4'hf, 3'h0, 16'h0);
        `CHK("wr data", 8'h01, n_ws)
        repeat (4) link(1'b1, 4'hf, 3'h0, 16'h0);
        m.set_term(1'b0);
        `CHK("issued", 16'h0101, {n_ir, n_iw})
        `CHK("dq driven", 1'b1, n_dq != 8'h00)
        `CHK("wr term", 1'b1, n_wt != 8'h00)
        link(1'b1, 4'h0, DMR_BA_MR1, 16'h1000);
        `CHK("qoff", 3'b111, {dq_oe_n, dm_oe_n, tc_oe_n})
        `CHK("term off", DMR_TERM_OFF, term.kind)
        link(1'b1, 4'h0, DMR_BA_MR1, 16'h0000);
        link(1'b0, 4'h1, 3'h0, 16'h0);
        `CHK("sr entry", 2'b10, {sref, dll_on})
        link(1'b1, 4'hf, 3'h0, 16'h0);
        `CHK("sr exit", 4'h4, {sref, dll_on, locked, wtr})
        link(1'b1, 4'h0, DMR_BA_MR2, 16'h005a);
        link(1'b1, 4'h0, DMR_BA_MR1, 16'h0001);
        `CHK("dll off", 2'b01, {dll_on, wtr})
        results;
    end
endmodule : dmr_top_tb_top
`default_nettype wire
